// ==== rtl/psc_defs.vh ====
`ifndef PSC_DEFS_VH
`define PSC_DEFS_VH
// ***********************************************************
// register map
// ***********************************************************
`define PSC_OVR_OFFSET 8'h5E
`define PSC_OVR_RESET 8'hFF
`define PSC_OVR_DOCP 0
`define PSC_OVR_AOCP 1
`define PSC_OVR_LCF 2
`define PSC_OVR_VBOOT 3
`define PSC_OVR_TON 4
`define PSC_OVR_MODE 5
`define PSC_OVR_FOVP 6
`define PSC_OVR_ROVP 7
// ***********************************************************
// units: frequency kHz, voltages mV
// ***********************************************************
`define PSC_FREQ_STEP_KHZ 12'd200
`define PSC_FREQ_MIN_KHZ 12'd400
`define PSC_FREQ_MAX_KHZ 12'd2000
`define PSC_FREQ_BAN_KHZ 12'd1600
`define PSC_VCMD_MIN_1X 13'd250
`define PSC_VCMD_MAX_1X 13'd2560
`define PSC_VCMD_MIN_2X 13'd500
`define PSC_VCMD_MAX_2X 13'd5120
`define PSC_VCMD_RESET 13'h0000
// power-good fractions in sixteenths: 15/16=93.75%, 13/16=81.25%
`define PSC_PG_ON_NUM 5'd15
`define PSC_PG_OFF_NUM 5'd13
`define PSC_PG_SHIFT 4
// default per-bin mode: 1 continuous, 0 diode emulation
`define PSC_MODE_MAP 16'h6004
`endif

// ==== rtl/psc_strap_decoder.v ====
`timescale 1ns/1ps
`include "psc_defs.vh"
// Summary of operation
// - override bit clear selects strap value
// - strapless variant: bus values, voltage from bus command (zero after reset)
// - frequency bin maps to fixed kHz table
// - frequency 400-2000 kHz, 200 grid, no 1600
// - frequency bin also selects conduction mode
// - boot voltage table at scale 1:1
// - relative and fixed OVP at scale 1:1
// - boot voltage table at scale 1:2
// - relative and fixed OVP at scale 1:2
// - power-good thresholds 93.75% and 81.25%
// - max voltage from strap relative OVP
// - command voltage range limited per scale
// - current-limit bin selects threshold, zero
module psc_strap_decoder #(
    parameter [15:0] MODE_MAP = `PSC_MODE_MAP,
    parameter STRAP_ENABLE = 1
) (
    input wire CLK_I,
    input wire RESETN_I,
    input wire CE_I,
    input wire [3:0] FREQ_BIN_I,
    input wire [3:0] VBT_BIN_I,
    input wire [3:0] ILIM_BIN_I,
    input wire BIN_VALID_I,
    input wire SCALE_2X_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    input wire [7:0] REG_ADDR_I,
    input wire [7:0] REG_WDATA_I,
    output reg [7:0] REG_RDATA_O,
    input wire [11:0] BUS_FREQ_KHZ_I,
    input wire BUS_CCM_I,
    input wire BUS_VCMD_WR_I,
    input wire [12:0] BUS_VCMD_MV_I,
    input wire [12:0] BUS_ROVP_MV_I,
    input wire [12:0] BUS_FOVP_MV_I,
    input wire [12:0] BUS_PG_ON_MV_I,
    input wire [12:0] BUS_PG_OFF_MV_I,
    input wire [12:0] BUS_VOUT_MAX_MV_I,
    input wire [3:0] BUS_DOCP_SEL_I,
    input wire [3:0] BUS_AOCP_SEL_I,
    input wire [3:0] BUS_LCF_SEL_I,
    output reg STRAP_LATCHED_O,
    output reg [11:0] FREQ_KHZ_O,
    output reg CCM_O,
    output reg [12:0] VOUT_MV_O,
    output reg [12:0] ROVP_MV_O,
    output reg [12:0] FOVP_MV_O,
    output reg [12:0] PG_ON_MV_O,
    output reg [12:0] PG_OFF_MV_O,
    output reg [12:0] VOUT_MAX_MV_O,
    output reg [3:0] DOCP_SEL_O,
    output reg [3:0] AOCP_SEL_O,
    output reg [3:0] LCF_SEL_O,
    output reg VCMD_REJECT_O
);
    // ***********************************************************
    // pin synchronisers
    // ***********************************************************
    reg [12:0] sync1_ff;
    reg [12:0] sync2_ff;
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            sync1_ff <= 13'h0000;
            sync2_ff <= 13'h0000;
        end else if (CE_I) begin
            sync1_ff <= {BIN_VALID_I, ILIM_BIN_I, VBT_BIN_I, FREQ_BIN_I};
            sync2_ff <= sync1_ff;
        end
    end
    // ***********************************************************
    // one-time strap capture
    // ***********************************************************
    reg latched_ff;
    reg [3:0] freq_bin_ff;
    reg [3:0] vbt_bin_ff;
    reg [3:0] ilim_bin_ff;
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            latched_ff <= 1'b0;
            freq_bin_ff <= 4'h0;
            vbt_bin_ff <= 4'h0;
            ilim_bin_ff <= 4'h0;
        end else if (CE_I && !latched_ff && sync2_ff[12]) begin
            latched_ff <= 1'b1;
            freq_bin_ff <= sync2_ff[3:0];
            vbt_bin_ff <= sync2_ff[7:4];
            ilim_bin_ff <= sync2_ff[11:8];
        end
    end
    // ***********************************************************
    // override register
    // ***********************************************************
    reg [7:0] ovr_ff;
    wire ovr_hit;
    assign ovr_hit = (REG_ADDR_I == `PSC_OVR_OFFSET);
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ovr_ff <= `PSC_OVR_RESET;
        end else if (CE_I && REG_WR_I && ovr_hit) begin
            ovr_ff <= REG_WDATA_I;
        end
    end
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            REG_RDATA_O <= 8'h00;
        end else if (CE_I && REG_RD_I) begin
            REG_RDATA_O <= ovr_hit ? ovr_ff : 8'h00;
        end
    end
    // strap usable only on strap variant after capture
    wire strap_ok;
    assign strap_ok = (STRAP_ENABLE != 0) && latched_ff;
    wire [7:0] use_strap;
    assign use_strap = strap_ok ? ~ovr_ff : 8'h00;
    // ***********************************************************
    // lookup
    // ***********************************************************
    wire [11:0] t_freq;
    wire [12:0] t_vboot;
    wire [12:0] t_rovp;
    wire [12:0] t_fovp;
    psc_strap_table u_table (
        .freq_bin_i(freq_bin_ff),
        .vbt_bin_i(vbt_bin_ff),
        .scale_2x_i(SCALE_2X_I),
        .freq_khz_o(t_freq),
        .vboot_mv_o(t_vboot),
        .rovp_mv_o(t_rovp),
        .fovp_mv_o(t_fovp)
    );
    // ***********************************************************
    // commanded voltage
    // ***********************************************************
    reg [12:0] vcmd_ff;
    wire [12:0] vmin;
    wire [12:0] vmax;
    wire vcmd_ok;
    assign vmin = SCALE_2X_I ? `PSC_VCMD_MIN_2X : `PSC_VCMD_MIN_1X;
    assign vmax = SCALE_2X_I ? `PSC_VCMD_MAX_2X : `PSC_VCMD_MAX_1X;
    assign vcmd_ok = (BUS_VCMD_MV_I >= vmin) && (BUS_VCMD_MV_I <= vmax);
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            vcmd_ff <= `PSC_VCMD_RESET;
            VCMD_REJECT_O <= 1'b0;
        end else if (CE_I) begin
            VCMD_REJECT_O <= BUS_VCMD_WR_I && !vcmd_ok;
            if (BUS_VCMD_WR_I && vcmd_ok) begin
                vcmd_ff <= BUS_VCMD_MV_I;
            end
        end
    end
    // ***********************************************************
    // selection
    // ***********************************************************
    wire [16:0] pg_on_p;
    wire [16:0] pg_off_p;
    wire [16:0] pg_on_s;
    wire [16:0] pg_off_s;
    assign pg_on_p = t_vboot * `PSC_PG_ON_NUM;
    assign pg_off_p = t_vboot * `PSC_PG_OFF_NUM;
    assign pg_on_s = pg_on_p >> `PSC_PG_SHIFT;
    assign pg_off_s = pg_off_p >> `PSC_PG_SHIFT;
    wire freq_ok;
    assign freq_ok = (t_freq >= `PSC_FREQ_MIN_KHZ) &&
        (t_freq <= `PSC_FREQ_MAX_KHZ) &&
        (t_freq % `PSC_FREQ_STEP_KHZ == 12'd0) &&
        (t_freq != `PSC_FREQ_BAN_KHZ);
    reg [11:0] nxt_freq;
    reg nxt_ccm;
    reg [12:0] nxt_vout;
    reg [12:0] nxt_rovp;
    reg [12:0] nxt_fovp;
    reg [12:0] nxt_pg_on;
    reg [12:0] nxt_pg_off;
    reg [12:0] nxt_vmax;
    reg [3:0] nxt_docp;
    reg [3:0] nxt_aocp;
    reg [3:0] nxt_lcf;
    always @* begin
        nxt_freq = BUS_FREQ_KHZ_I;
        if (use_strap[`PSC_OVR_TON] && freq_ok) begin
            nxt_freq = t_freq;
        end
        nxt_ccm = use_strap[`PSC_OVR_MODE] ?
            MODE_MAP[freq_bin_ff] : BUS_CCM_I;
        nxt_vout = vcmd_ff;
        nxt_pg_on = BUS_PG_ON_MV_I;
        nxt_pg_off = BUS_PG_OFF_MV_I;
        nxt_vmax = BUS_VOUT_MAX_MV_I;
        if (use_strap[`PSC_OVR_VBOOT]) begin
            nxt_vout = t_vboot;
            nxt_pg_on = pg_on_s[12:0];
            nxt_pg_off = pg_off_s[12:0];
            nxt_vmax = t_rovp;
        end
        nxt_rovp = use_strap[`PSC_OVR_ROVP] ?
            t_rovp : BUS_ROVP_MV_I;
        nxt_fovp = use_strap[`PSC_OVR_FOVP] ?
            t_fovp : BUS_FOVP_MV_I;
        nxt_docp = use_strap[`PSC_OVR_DOCP] ?
            ilim_bin_ff : BUS_DOCP_SEL_I;
        nxt_aocp = use_strap[`PSC_OVR_AOCP] ?
            ilim_bin_ff : BUS_AOCP_SEL_I;
        nxt_lcf = use_strap[`PSC_OVR_LCF] ?
            ilim_bin_ff : BUS_LCF_SEL_I;
    end
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            STRAP_LATCHED_O <= 1'b0;
            FREQ_KHZ_O <= 12'h000;
            CCM_O <= 1'b0;
            VOUT_MV_O <= 13'h0000;
            ROVP_MV_O <= 13'h0000;
            FOVP_MV_O <= 13'h0000;
            PG_ON_MV_O <= 13'h0000;
            PG_OFF_MV_O <= 13'h0000;
            VOUT_MAX_MV_O <= 13'h0000;
            DOCP_SEL_O <= 4'h0;
            AOCP_SEL_O <= 4'h0;
            LCF_SEL_O <= 4'h0;
        end else if (CE_I) begin
            STRAP_LATCHED_O <= latched_ff;
            FREQ_KHZ_O <= nxt_freq;
            CCM_O <= nxt_ccm;
            VOUT_MV_O <= nxt_vout;
            ROVP_MV_O <= nxt_rovp;
            FOVP_MV_O <= nxt_fovp;
            PG_ON_MV_O <= nxt_pg_on;
            PG_OFF_MV_O <= nxt_pg_off;
            VOUT_MAX_MV_O <= nxt_vmax;
            DOCP_SEL_O <= nxt_docp;
            AOCP_SEL_O <= nxt_aocp;
            LCF_SEL_O <= nxt_lcf;
        end
    end
endmodule // psc_strap_decoder

// ==== rtl/psc_strap_table.v ====
`timescale 1ns/1ps
`include "psc_defs.vh"
// ***********************************************************
// bin to setting lookup
// ***********************************************************
module psc_strap_table (
    input wire [3:0] freq_bin_i,
    input wire [3:0] vbt_bin_i,
    input wire scale_2x_i,
    output reg [11:0] freq_khz_o,
    output reg [12:0] vboot_mv_o,
    output reg [12:0] rovp_mv_o,
    output reg [12:0] fovp_mv_o
);
    always @* begin
        case (freq_bin_i)
            4'h0: freq_khz_o = 12'd600;
            4'h1: freq_khz_o = 12'd1000;
            4'h2: freq_khz_o = 12'd1400;
            4'h3: freq_khz_o = 12'd2000;
            4'h4: freq_khz_o = 12'd1200;
            4'h5: freq_khz_o = 12'd1400;
            4'h6: freq_khz_o = 12'd1800;
            4'h7: freq_khz_o = 12'd2000;
            4'h8: freq_khz_o = 12'd400;
            4'h9: freq_khz_o = 12'd600;
            4'hA: freq_khz_o = 12'd800;
            4'hB: freq_khz_o = 12'd1000;
            4'hC: freq_khz_o = 12'd400;
            4'hD: freq_khz_o = 12'd1800;
            4'hE: freq_khz_o = 12'd1200;
            default: freq_khz_o = 12'd800;
        endcase
    end
    always @* begin
        if (!scale_2x_i) begin
            case (vbt_bin_i)
                4'h0: vboot_mv_o = 13'd400;
                4'h1: vboot_mv_o = 13'd500;
                4'h2: vboot_mv_o = 13'd600;
                4'h3: vboot_mv_o = 13'd700;
                4'h4: vboot_mv_o = 13'd800;
                4'h5: vboot_mv_o = 13'd900;
                4'h6: vboot_mv_o = 13'd1000;
                4'h7: vboot_mv_o = 13'd1050;
                4'h8: vboot_mv_o = 13'd1100;
                4'h9: vboot_mv_o = 13'd1200;
                4'hA: vboot_mv_o = 13'd1250;
                4'hB: vboot_mv_o = 13'd1350;
                4'hC: vboot_mv_o = 13'd1500;
                4'hD: vboot_mv_o = 13'd1650;
                4'hE: vboot_mv_o = 13'd1800;
                default: vboot_mv_o = 13'd2500;
            endcase
            case (vbt_bin_i)
                4'h0, 4'h1, 4'h2, 4'h3: rovp_mv_o = 13'd150;
                4'hA, 4'hB: rovp_mv_o = 13'd250;
                4'hC, 4'hD, 4'hE, 4'hF: rovp_mv_o = 13'd300;
                default: rovp_mv_o = 13'd200;
            endcase
            case (vbt_bin_i)
                4'h0: fovp_mv_o = 13'd800;
                4'h1, 4'h2: fovp_mv_o = 13'd1000;
                4'h3, 4'h4, 4'h5: fovp_mv_o = 13'd1200;
                4'h6, 4'h7, 4'h8: fovp_mv_o = 13'd1350;
                4'h9: fovp_mv_o = 13'd1500;
                4'hA, 4'hB: fovp_mv_o = 13'd1800;
                4'hC, 4'hD, 4'hE: fovp_mv_o = 13'd2200;
                default: fovp_mv_o = 13'd2850;
            endcase
        end else begin
            case (vbt_bin_i)
                4'h0: vboot_mv_o = 13'd800;
                4'h1: vboot_mv_o = 13'd1000;
                4'h2: vboot_mv_o = 13'd1200;
                4'h3: vboot_mv_o = 13'd1400;
                4'h4: vboot_mv_o = 13'd1600;
                4'h5: vboot_mv_o = 13'd1800;
                4'h6: vboot_mv_o = 13'd2000;
                4'h7: vboot_mv_o = 13'd2100;
                4'h8: vboot_mv_o = 13'd2200;
                4'h9: vboot_mv_o = 13'd2400;
                4'hA: vboot_mv_o = 13'd2500;
                4'hB: vboot_mv_o = 13'd2700;
                4'hC: vboot_mv_o = 13'd3000;
                4'hD: vboot_mv_o = 13'd3300;
                4'hE: vboot_mv_o = 13'd3600;
                default: vboot_mv_o = 13'd5000;
            endcase
            case (vbt_bin_i)
                4'h0, 4'h1, 4'h2: rovp_mv_o = 13'd200;
                default: rovp_mv_o = 13'd300;
            endcase
            case (vbt_bin_i)
                4'h0, 4'h1, 4'h2: fovp_mv_o = 13'd1600;
                4'h3: fovp_mv_o = 13'd2000;
                4'h4, 4'h5: fovp_mv_o = 13'd2400;
                4'h6, 4'h7, 4'h8: fovp_mv_o = 13'd2700;
                4'h9, 4'hA: fovp_mv_o = 13'd3000;
                4'hB, 4'hC: fovp_mv_o = 13'd3600;
                4'hD, 4'hE: fovp_mv_o = 13'd4400;
                default: fovp_mv_o = 13'd5700;
            endcase
        end
    end
endmodule // psc_strap_table

// ==== testbench/psc_strap_decoder_bench.sv ====
`timescale 1ns/1ps
`include "psc_defs.vh"
module psc_strap_decoder_bench;
    logic CLK_I = 1'b0, RESETN_I = 1'b0, CE_I = 1'b1, SCALE_2X_I = 1'b0;
    logic REG_WR_I = 1'b0, REG_RD_I = 1'b0, BUS_VCMD_WR_I = 1'b0;
    logic BUS_CCM_I = 1'b0, BIN_VALID_I, STRAP_LATCHED_O, CCM_O;
    logic VCMD_REJECT_O, pres = 1'b0;
    logic [7:0] REG_ADDR_I = 8'h00, REG_WDATA_I = 8'h00, REG_RDATA_O;
    logic [3:0] FREQ_BIN_I, VBT_BIN_I, ILIM_BIN_I, il;
    logic [3:0] BUS_DOCP_SEL_I = 4'h0, BUS_AOCP_SEL_I = 4'h0;
    logic [3:0] BUS_LCF_SEL_I = 4'h0, DOCP_SEL_O, AOCP_SEL_O, LCF_SEL_O;
    logic [11:0] BUS_FREQ_KHZ_I = 12'h000, FREQ_KHZ_O, code = 12'h000;
    logic [12:0] BUS_VCMD_MV_I = 13'h0000, BUS_ROVP_MV_I = 13'h0000;
    logic [12:0] BUS_FOVP_MV_I = 13'h0000, BUS_PG_ON_MV_I = 13'h0000;
    logic [12:0] BUS_PG_OFF_MV_I = 13'h0000, BUS_VOUT_MAX_MV_I = 13'h0000;
    logic [12:0] VOUT_MV_O, ROVP_MV_O, FOVP_MV_O, PG_ON_MV_O, vset;
    logic [12:0] PG_OFF_MV_O, VOUT_MAX_MV_O, lo, hi;
    logic [15:0] mm = `PSC_MODE_MAP;
    logic [12:0] bus_vout;
    logic [11:0] bus_freq;
    int miscompares = 0, checks = 0, r;
    int fq[16] = '{600, 1000, 1400, 2000, 1200, 1400, 1800, 2000,
        400, 600, 800, 1000, 400, 1800, 1200, 800};
    int v1[16] = '{400, 500, 600, 700, 800, 900, 1000, 1050,
        1100, 1200, 1250, 1350, 1500, 1650, 1800, 2500};
    int v2[16] = '{800, 1000, 1200, 1400, 1600, 1800, 2000, 2100,
        2200, 2400, 2500, 2700, 3000, 3300, 3600, 5000};
    int f1[16] = '{800, 1000, 1000, 1200, 1200, 1200, 1350, 1350,
        1350, 1500, 1800, 1800, 2200, 2200, 2200, 2850};
    int f2[16] = '{1600, 1600, 1600, 2000, 2400, 2400, 2700, 2700,
        2700, 3000, 3000, 3600, 3600, 4400, 4400, 5700};
    always #2 CLK_I = ~CLK_I;
    psc_strap_pins pins (.clk_i(CLK_I), .present_i(pres), .code_i(code),
        .bins_o({ILIM_BIN_I, VBT_BIN_I, FREQ_BIN_I}), .valid_o(BIN_VALID_I));
    psc_strap_decoder uut (
        .CLK_I, .RESETN_I, .CE_I, .FREQ_BIN_I, .VBT_BIN_I, .ILIM_BIN_I,
        .BIN_VALID_I, .SCALE_2X_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I,
        .REG_WDATA_I, .REG_RDATA_O, .BUS_FREQ_KHZ_I, .BUS_CCM_I,
        .BUS_VCMD_WR_I, .BUS_VCMD_MV_I, .BUS_ROVP_MV_I, .BUS_FOVP_MV_I,
        .BUS_PG_ON_MV_I, .BUS_PG_OFF_MV_I, .BUS_VOUT_MAX_MV_I,
        .BUS_DOCP_SEL_I, .BUS_AOCP_SEL_I, .BUS_LCF_SEL_I, .STRAP_LATCHED_O,
        .FREQ_KHZ_O, .CCM_O, .VOUT_MV_O, .ROVP_MV_O, .FOVP_MV_O,
        .PG_ON_MV_O, .PG_OFF_MV_O, .VOUT_MAX_MV_O, .DOCP_SEL_O,
        .AOCP_SEL_O, .LCF_SEL_O, .VCMD_REJECT_O);
    // strapless variant sharing every input
    psc_strap_decoder #(.STRAP_ENABLE(0)) uut_bus (.*,
        .REG_RDATA_O(), .STRAP_LATCHED_O(), .FREQ_KHZ_O(bus_freq),
        .CCM_O(), .VOUT_MV_O(bus_vout), .ROVP_MV_O(), .FOVP_MV_O(),
        .PG_ON_MV_O(), .PG_OFF_MV_O(), .VOUT_MAX_MV_O(), .DOCP_SEL_O(),
        .AOCP_SEL_O(), .LCF_SEL_O(), .VCMD_REJECT_O());
    // ****
    // expectations and bus tasks
    // ****
    function automatic int rv(int b, bit s);
        if (s) return b < 3 ? 200 : 300;
        return b < 4 ? 150 : b < 10 ? 200 : b < 12 ? 250 : 300;
    endfunction
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_I);
    endtask
    task automatic wreg(input logic [7:0] d);
        @(posedge CLK_I);
        REG_WR_I <= 1'b1;
        REG_ADDR_I <= 8'h5E;
        REG_WDATA_I <= d;
        @(posedge CLK_I);
        REG_WR_I <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge CLK_I);
        REG_RD_I <= 1'b1;
        REG_ADDR_I <= a;
        @(posedge CLK_I);
        REG_RD_I <= 1'b0;
        #1 chk({5'h00, REG_RDATA_O}, {5'h00, e});
    endtask
    task automatic vcmd(input logic [12:0] mv, input logic rej);
        @(posedge CLK_I);
        BUS_VCMD_WR_I <= 1'b1;
        BUS_VCMD_MV_I <= mv;
        @(posedge CLK_I);
        BUS_VCMD_WR_I <= 1'b0;
        #1 chk({12'h000, VCMD_REJECT_O}, {12'h000, rej});
        if (!rej) vset = mv;
        @(posedge CLK_I);
        #1 chk(VOUT_MV_O, vset);
    endtask
    task automatic boot(input logic [11:0] c);
        @(posedge CLK_I);
        RESETN_I <= 1'b0;
        pres <= 1'b0;
        code <= c;
        vset = 13'h0000;
        tick(4);
        RESETN_I <= 1'b1;
        pres <= 1'b1;
        #1;
        repeat (40) if (!STRAP_LATCHED_O) #4;
        chk({12'h000, STRAP_LATCHED_O}, 13'h0001);
    endtask
    task automatic strap_chk(input int b);
        int v;
        v = 15 - b;
        for (int s = 0; s < 2; s++) begin
            SCALE_2X_I <= s[0];
            tick(2);
            #1 chk({1'b0, FREQ_KHZ_O}, 13'(fq[b]));
            chk({1'b0, bus_freq}, {1'b0, BUS_FREQ_KHZ_I});
            chk(bus_vout, vset);
            chk({12'h000, CCM_O}, {12'h000, mm[b]});
            chk(VOUT_MV_O, 13'(s ? v2[v] : v1[v]));
            chk(ROVP_MV_O, 13'(rv(v, s)));
            chk(FOVP_MV_O, 13'(s ? f2[v] : f1[v]));
            chk(PG_ON_MV_O, 13'((s ? v2[v] : v1[v]) * 15 / 16));
            chk(PG_OFF_MV_O, 13'((s ? v2[v] : v1[v]) * 13 / 16));
            chk(VOUT_MAX_MV_O, 13'(rv(v, s)));
            chk({9'h000, DOCP_SEL_O ^ AOCP_SEL_O ^ LCF_SEL_O}, {9'h000, il});
        end
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        logic [12:0] g[8], sv[8], bv[8];
        r = $urandom(4985);
        tick(16);
        for (int b = 0; b < 16; b++) begin
            il = 4'($urandom);
            boot({il, 4'(15 - b), 4'(b)});
            rreg(8'h5E, 8'hFF);
            wreg(8'h00);
            strap_chk(b);
            $display("strap bin %0d done", b);
        end
        code <= 12'hA5C;
        tick(20);
        strap_chk(15);
        $display("latch hold done");
        BUS_FREQ_KHZ_I <= 12'(400 + 200 * $urandom_range(8));
        BUS_CCM_I <= ~mm[15];
        {BUS_DOCP_SEL_I, BUS_AOCP_SEL_I, BUS_LCF_SEL_I} <= 12'($urandom);
        BUS_FOVP_MV_I <= 13'($urandom);
        BUS_ROVP_MV_I <= 13'($urandom);
        BUS_PG_ON_MV_I <= 13'($urandom);
        BUS_PG_OFF_MV_I <= 13'($urandom);
        BUS_VOUT_MAX_MV_I <= 13'($urandom);
        SCALE_2X_I <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            wreg(8'h01 << k);
            tick(2);
            #1 g = '{DOCP_SEL_O, AOCP_SEL_O, LCF_SEL_O, VOUT_MV_O,
                FREQ_KHZ_O, CCM_O, FOVP_MV_O, ROVP_MV_O};
            sv = '{il, il, il, v1[0], fq[15], mm[15], f1[0], rv(0, 0)};
            bv = '{BUS_DOCP_SEL_I, BUS_AOCP_SEL_I, BUS_LCF_SEL_I, vset,
                BUS_FREQ_KHZ_I, BUS_CCM_I, BUS_FOVP_MV_I, BUS_ROVP_MV_I};
            for (int j = 0; j < 8; j++) chk(g[j], j == k ? bv[j] : sv[j]);
            if (k == 3) begin
                chk(PG_ON_MV_O, BUS_PG_ON_MV_I);
                chk(PG_OFF_MV_O, BUS_PG_OFF_MV_I);
                chk(VOUT_MAX_MV_O, BUS_VOUT_MAX_MV_I);
            end
        end
        $display("override bits done");
        wreg(8'hFF);
        rreg(8'h5D, 8'h00);
        for (int s = 0; s < 2; s++) begin
            SCALE_2X_I <= s[0];
            lo = s ? 13'h01F4 : 13'h00FA;
            hi = s ? 13'h1400 : 13'h0A00;
            vcmd(lo - 13'h0001, 1'b1);
            vcmd(lo, 1'b0);
            vcmd(hi, 1'b0);
            vcmd(hi + 13'h0001, 1'b1);
            vcmd(lo + 13'($urandom_range(hi - lo)), 1'b0);
        end
        // clock enable low must freeze the stored command
        @(posedge CLK_I);
        CE_I <= 1'b0;
        BUS_VCMD_WR_I <= 1'b1;
        BUS_VCMD_MV_I <= 13'h03E8;
        tick(2);
        BUS_VCMD_WR_I <= 1'b0;
        tick(2);
        #1 chk(VOUT_MV_O, vset);
        chk({12'h000, VCMD_REJECT_O}, 13'h0000);
        @(posedge CLK_I);
        CE_I <= 1'b1;
        tick(2);
        #1 chk(VOUT_MV_O, vset);
        $display("voltage command done");
        complete_run();
    end
    initial begin
        tick(20000);
        miscompares++;
        complete_run();
    end
endmodule // psc_strap_decoder_bench

// ==== testbench/psc_strap_monitor.sv ====
`timescale 1ns/1ps
// ****
// port checker
// ****
module psc_strap_monitor #(
    parameter STRAP_ENABLE = 1
) (
    input wire CLK_I,
    input wire RESETN_I,
    input wire CE_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    input wire [7:0] REG_ADDR_I,
    input wire [7:0] REG_WDATA_I,
    input wire [7:0] REG_RDATA_O,
    input wire SCALE_2X_I,
    input wire BUS_VCMD_WR_I,
    input wire [12:0] BUS_VCMD_MV_I,
    input wire [11:0] BUS_FREQ_KHZ_I,
    input wire STRAP_LATCHED_O,
    input wire [11:0] FREQ_KHZ_O,
    input wire [12:0] VOUT_MV_O,
    input wire [12:0] ROVP_MV_O,
    input wire [12:0] PG_ON_MV_O,
    input wire [12:0] PG_OFF_MV_O,
    input wire [12:0] VOUT_MAX_MV_O,
    input wire VCMD_REJECT_O
);
    reg [7:0] ovr_ff;
    reg [1:0] age_ff;
    wire go = CE_I && age_ff[1];
    wire st = STRAP_ENABLE != 0 && STRAP_LATCHED_O;
    wire [12:0] lo = SCALE_2X_I ? 13'h01F4 : 13'h00FA;
    wire [12:0] hi = SCALE_2X_I ? 13'h1400 : 13'h0A00;
    wire vok = BUS_VCMD_MV_I >= lo && BUS_VCMD_MV_I <= hi;
    // shadow of the override register
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ovr_ff <= 8'hFF;
            age_ff <= 2'h0;
        end else if (CE_I) begin
            if (REG_WR_I && REG_ADDR_I == 8'h5E) ovr_ff <= REG_WDATA_I;
            if (!age_ff[1]) age_ff <= age_ff + 2'h1;
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    vcmd_reject_a: assert property (go && BUS_VCMD_WR_I && !vok
        |=> VCMD_REJECT_O) else $error("bad command not rejected");
    freq_grid_a: assert property (go && st && !ovr_ff[4] |=>
        FREQ_KHZ_O >= 12'h190 && FREQ_KHZ_O <= 12'h7D0 &&
        FREQ_KHZ_O % 12'h0C8 == 12'h000 && FREQ_KHZ_O != 12'h640)
        else $error("strap frequency off grid");
    pg_track_a: assert property (go && st && !ovr_ff[3] |=>
        PG_ON_MV_O == 13'(({4'h0, VOUT_MV_O} * 17'h0000F) >> 4) &&
        PG_OFF_MV_O == 13'(({4'h0, VOUT_MV_O} * 17'h0000D) >> 4))
        else $error("power-good levels wrong");
    vmax_rovp_a: assert property (go && st && !ovr_ff[3] && !ovr_ff[7]
        |=> VOUT_MAX_MV_O == ROVP_MV_O) else $error("max voltage wrong");
    freq_bus_a: assert property (go && (ovr_ff[4] || !st)
        |=> FREQ_KHZ_O == $past(BUS_FREQ_KHZ_I))
        else $error("bus frequency not used");
    latch_hold_a: assert property (STRAP_LATCHED_O && CE_I
        |=> STRAP_LATCHED_O) else $error("latched flag dropped");
    read_map_a: assert property (go && REG_RD_I && REG_ADDR_I == 8'h5E
        |=> REG_RDATA_O == $past(ovr_ff)) else $error("override readback");
    read_unmap_a: assert property (go && REG_RD_I && REG_ADDR_I != 8'h5E
        |=> REG_RDATA_O == 8'h00) else $error("unmapped read");
endmodule // psc_strap_monitor
bind psc_strap_decoder psc_strap_monitor #(.STRAP_ENABLE(STRAP_ENABLE)) mon (
    .CLK_I, .RESETN_I, .CE_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I,
    .REG_WDATA_I, .REG_RDATA_O, .SCALE_2X_I, .BUS_VCMD_WR_I, .BUS_VCMD_MV_I,
    .BUS_FREQ_KHZ_I, .STRAP_LATCHED_O, .FREQ_KHZ_O, .VOUT_MV_O, .ROVP_MV_O,
    .PG_ON_MV_O, .PG_OFF_MV_O, .VOUT_MAX_MV_O, .VCMD_REJECT_O);

// ==== testbench/psc_strap_pins.sv ====
`timescale 1ns/1ps
// ****
// strap resistors and bin converter
// ****
module psc_strap_pins (
    input wire clk_i,
    input wire present_i,
    input wire [11:0] code_i,
    output reg [11:0] bins_o = 12'h000,
    output reg valid_o = 1'b0
);
    reg [2:0] cnt_ff = 3'h0;
    // bins toggle while the strap is not present
    always @(posedge clk_i) begin
        if (!present_i) begin
            cnt_ff <= 3'h0;
            valid_o <= 1'b0;
            bins_o <= ~bins_o;
        end else begin
            if (cnt_ff != 3'h7) cnt_ff <= cnt_ff + 3'h1;
            valid_o <= cnt_ff == 3'h7;
            bins_o <= code_i;
        end
    end
endmodule // psc_strap_pins
